// file: inc/seq_rom_pkg.sv
package seq_rom_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [23:0] PIN_FUNC_ADDR = 24'h300F66; // Byte register.
  localparam logic [23:0] AREA_SEL_ADDR = 24'h3A0100; // Halfword register.
  localparam logic [7:0] PIN_FUNC_RESET = 8'h00; // All pins as ports.
  localparam logic [15:0] AREA_SEL_RESET = 16'h0000; // Default area.
  localparam int PIN0_FIELD_LSB = 0; // Read strobe pin field.
  localparam int PIN1_FIELD_LSB = 2; // Lower latch enable pin field.
  localparam int PIN2_FIELD_LSB = 4; // Upper latch enable pin field.
  localparam int PIN_FIELD_BITS = 6; // Implemented bits of pin register.
  localparam int AREA_FIELD_BITS = 2; // Implemented area-select bits.

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FUNC_PORT = 2'h0; // General port use.
  localparam logic [1:0] FUNC_ROM = 2'h1; // ROM signal on the pin.
  localparam logic [1:0] LE_UPPER_IN = 2'h3; // Upper address input.
  localparam logic [1:0] LE_STANDBY = 2'h2; // Standby.
  localparam logic [1:0] LE_LOWER_IN = 2'h1; // Lower address input.
  localparam logic [1:0] LE_ACTIVE = 2'h0; // Active read.
  localparam logic [1:0] MAP_MODE_0 = 2'h0; // Default chip-enable map.
  localparam logic [1:0] MAP_MODE_1 = 2'h1; // Second chip-enable map.

  // Chip-enable line numbers per area code, one table for map 0 and one for map 1, which map 1x also uses.
  localparam logic [4:0] CE_M0_A3 = 5'h09;
  localparam logic [4:0] CE_M0_A2 = 5'h08;
  localparam logic [4:0] CE_M0_A1 = 5'h07;
  localparam logic [4:0] CE_M0_A0 = 5'h05;
  localparam logic [4:0] CE_M1_A3 = 5'h11;
  localparam logic [4:0] CE_M1_A2 = 5'h0E;
  localparam logic [4:0] CE_M1_A1 = 5'h0D;
  localparam logic [4:0] CE_M1_A0 = 5'h0F;
  localparam logic [4:0] CE_M2_A3X = 5'h12; // Paired line in map 1x.
  localparam logic [4:0] CE_M2_A0X = 5'h10; // Paired line in map 1x.

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // One CPU bus cycle as seen by the block.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:1] addr;
  } bus_cycle_t;

  // One access to the control registers.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

endpackage

// file: hw/sequential_rom_interface.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Small FIFO for ROM read data
// ------------------------------------------------------------------
module seq_rom_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointers and fill count; the words sit in a plain array.
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic not_empty; // Registered copy of a non-zero count.
  } fifo_state_t;

  fifo_state_t state_reg; // Registered pointers.
  fifo_state_t state_next; // Next pointers.
  logic [WIDTH-1:0] mem [DEPTH]; // Data storage.
  logic push; // Word accepted this cycle.
  logic pop; // Word delivered this cycle.

  assign in_ready_o = (state_reg.count != (AW+1)'(DEPTH));
  assign out_valid_o = state_reg.not_empty;
  assign out_data_o = mem[state_reg.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Advance the pointers; wrap explicitly so any depth works.
  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.wr_ptr = (state_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : state_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_next.rd_ptr = (state_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : state_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + 1'b1;
    end else if (pop && !push) begin
      state_next.count = state_reg.count - 1'b1;
    end
    // Valid comes from its own flop, so the output does not ripple.
    state_next.not_empty = (state_next.count != '0);
  end

  // Storage needs no reset; empty is tracked by the count.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[state_reg.wr_ptr] <= in_data_i;
    end
  end

  // Pointer registers.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule // seq_rom_fifo

// ------------------------------------------------------------------
// Sequential ROM interface top
// ------------------------------------------------------------------
module sequential_rom_interface #(
  parameter int DATA_WIDTH = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hot_start_i,
  input wire seq_rom_pkg::reg_req_t reg_req_i,
  output logic [15:0] reg_rdata_o,
  input wire seq_rom_pkg::bus_cycle_t bus_cycle_i,
  input wire logic [18:0] ce_n_i,
  input wire logic [1:0] chip_enable_map_mode_i,
  output logic bus_wait_o,
  input wire logic [DATA_WIDTH-1:0] rom_data_i,
  output logic [DATA_WIDTH-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  input wire logic [2:0] gpio_out_i,
  input wire logic [2:0] gpio_oe_i,
  output logic [2:0] gpio_in_o,
  input wire logic [2:0] pin_in_i,
  output logic [2:0] pin_out_o,
  output logic [2:0] pin_oe_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Cleared by any reset, except le (standby) and the strobe (high).
  typedef struct packed {
    logic [seq_rom_pkg::AREA_FIELD_BITS-1:0] area_sel;
    logic [1:0] le; // Upper enable in bit 1, lower in bit 0.
    logic rd_strobe_n; // Registered read strobe.
    logic rd_hit_d; // Area read seen last cycle.
    logic [DATA_WIDTH-1:0] rom_data; // Last word sampled in a read.
    logic [15:0] rdata; // Register read data.
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic [2:0] gpio_in;
    logic fifo_full; // High while the FIFO cannot take a word.
  } ctrl_state_t;

  // The pin register survives a hot start, so it has its own flops.
  typedef struct packed {
    logic [seq_rom_pkg::PIN_FIELD_BITS-1:0] pin_func;
  } keep_state_t;

  ctrl_state_t state_reg; // Registered control state.
  ctrl_state_t state_next; // Next control state.
  keep_state_t keep_reg; // Registered pin functions.
  keep_state_t keep_next; // Next pin functions.
  logic area_hit; // Selected chip-enable line is active.
  logic rd_hit; // Read cycle to the ROM area.
  logic wr_hit; // Write cycle to the ROM area.
  logic fifo_in_ready; // FIFO can accept a word.
  logic fifo_push; // Word leaves a finished read.
  logic [1:0] f0; // Read strobe pin field.
  logic [1:0] f1; // Lower latch pin field.
  logic [1:0] f2; // Upper latch pin field.
  logic [2:0] rom_sig; // ROM-side pin levels.
  logic [2:0] rom_on; // Pin is given to the ROM.

  // ----------------------------------------------------------------
  // Area decode
  // ----------------------------------------------------------------
  // Chip-enable lines are active low; map 1x pairs two lines.
  always_comb begin
    area_hit = 1'b0;
    unique case (chip_enable_map_mode_i)
      seq_rom_pkg::MAP_MODE_0: begin
        unique case (state_reg.area_sel)
          2'h3: area_hit = !ce_n_i[seq_rom_pkg::CE_M0_A3];
          2'h2: area_hit = !ce_n_i[seq_rom_pkg::CE_M0_A2];
          2'h1: area_hit = !ce_n_i[seq_rom_pkg::CE_M0_A1];
          2'h0: area_hit = !ce_n_i[seq_rom_pkg::CE_M0_A0];
        endcase
      end
      seq_rom_pkg::MAP_MODE_1: begin
        unique case (state_reg.area_sel)
          2'h3: area_hit = !ce_n_i[seq_rom_pkg::CE_M1_A3];
          2'h2: area_hit = !ce_n_i[seq_rom_pkg::CE_M1_A2];
          2'h1: area_hit = !ce_n_i[seq_rom_pkg::CE_M1_A1];
          2'h0: area_hit = !ce_n_i[seq_rom_pkg::CE_M1_A0];
        endcase
      end
      default: begin
        // Map 1x: the upper and lowest codes span two lines.
        unique case (state_reg.area_sel)
          2'h3: area_hit = !ce_n_i[seq_rom_pkg::CE_M1_A3] ||
                           !ce_n_i[seq_rom_pkg::CE_M2_A3X];
          2'h2: area_hit = !ce_n_i[seq_rom_pkg::CE_M1_A2];
          2'h1: area_hit = !ce_n_i[seq_rom_pkg::CE_M1_A1];
          2'h0: area_hit = !ce_n_i[seq_rom_pkg::CE_M1_A0] ||
                           !ce_n_i[seq_rom_pkg::CE_M2_A0X];
        endcase
      end
    endcase
  end

  assign rd_hit = area_hit && bus_cycle_i.rd;
  assign wr_hit = area_hit && bus_cycle_i.wr;
  // A read pushes its word when the cycle ends, so the last sample wins.
  assign fifo_push = state_reg.rd_hit_d && !rd_hit;

  assign f0 = keep_reg.pin_func[seq_rom_pkg::PIN0_FIELD_LSB +: 2];
  assign f1 = keep_reg.pin_func[seq_rom_pkg::PIN1_FIELD_LSB +: 2];
  assign f2 = keep_reg.pin_func[seq_rom_pkg::PIN2_FIELD_LSB +: 2];
  // Reserved codes leave the pin as a port, the safe choice.
  assign rom_on = {f2 == seq_rom_pkg::FUNC_ROM, f1 == seq_rom_pkg::FUNC_ROM,
                   f0 == seq_rom_pkg::FUNC_ROM};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    keep_next = keep_reg;
    state_next.rd_hit_d = rd_hit;
    if (rd_hit) begin
      state_next.rom_data = rom_data_i;
    end
    // Strobe low only while the area is being read.
    state_next.rd_strobe_n = !rd_hit;
    if (rd_hit) begin
      // Reads ignore address bits 2:1 and keep the ROM active.
      state_next.le = seq_rom_pkg::LE_ACTIVE;
    end else if (wr_hit) begin
      // 11 upper input, 10 standby, 01 lower input, 00 active.
      state_next.le = bus_cycle_i.addr;
    end
    // Register writes; halfword register takes the low two bits.
    if (reg_req_i.wr && reg_req_i.addr == seq_rom_pkg::PIN_FUNC_ADDR) begin
      keep_next.pin_func = reg_req_i.wdata[seq_rom_pkg::PIN_FIELD_BITS-1:0];
    end
    if (reg_req_i.wr && reg_req_i.addr == seq_rom_pkg::AREA_SEL_ADDR) begin
      state_next.area_sel = reg_req_i.wdata[seq_rom_pkg::AREA_FIELD_BITS-1:0];
    end
    // Register reads; reserved bits and unmapped addresses give zero.
    state_next.rdata = 16'h0000;
    if (reg_req_i.rd && reg_req_i.addr == seq_rom_pkg::PIN_FUNC_ADDR) begin
      state_next.rdata = {10'h000, keep_reg.pin_func};
    end else if (reg_req_i.rd && reg_req_i.addr == seq_rom_pkg::AREA_SEL_ADDR) begin
      state_next.rdata = {14'h0000, state_reg.area_sel};
    end
    // Pin multiplexer: ROM levels or the general port.
    rom_sig = {state_next.le, state_next.rd_strobe_n};
    state_next.pin_out = (rom_on & rom_sig) | (~rom_on & gpio_out_i);
    state_next.pin_oe = rom_on | gpio_oe_i;
    state_next.gpio_in = pin_in_i;
    // Hold off new reads while the FIFO is full.
    state_next.fifo_full = !fifo_in_ready;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Control flops: constants under reset, standby on the ROM side.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
      state_reg.area_sel <= seq_rom_pkg::AREA_SEL_RESET[1:0];
      state_reg.le <= seq_rom_pkg::LE_STANDBY;
      state_reg.rd_strobe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pin register: a cold reset clears it while the clock runs during
  // reset; a hot start leaves it alone. An async clear would lose it.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      if (!hot_start_i) begin
        keep_reg.pin_func <= seq_rom_pkg::PIN_FUNC_RESET[5:0];
      end
    end else begin
      keep_reg <= keep_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data buffer
  // ----------------------------------------------------------------
  // Output data comes from the FIFO array, itself a flop store.
  seq_rom_fifo #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(state_reg.rom_data),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o)
  );

  assign reg_rdata_o = state_reg.rdata;
  assign bus_wait_o = state_reg.fifo_full;
  assign pin_out_o = state_reg.pin_out;
  assign pin_oe_o = state_reg.pin_oe;
  assign gpio_in_o = state_reg.gpio_in;

endmodule // sequential_rom_interface

// file: bench/seq_rom_sva.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Checker for the sequential ROM interface
// ------------------------------------------------------------
module seq_rom_sva #(
  parameter int DATA_WIDTH = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hot_start_i,
  input wire seq_rom_pkg::reg_req_t reg_req_i,
  input wire logic [15:0] reg_rdata_o,
  input wire seq_rom_pkg::bus_cycle_t bus_cycle_i,
  input wire logic [18:0] ce_n_i,
  input wire logic [1:0] chip_enable_map_mode_i,
  input wire logic rd_valid_o,
  input wire logic rd_ready_i,
  input wire logic [2:0] gpio_oe_i,
  input wire logic [2:0] pin_out_o,
  input wire logic [2:0] pin_oe_o
);
  localparam logic [23:0] PA = seq_rom_pkg::PIN_FUNC_ADDR;
  localparam logic [23:0] AA = seq_rom_pkg::AREA_SEL_ADDR;
  logic [1:0] area_reg; // Shadow of the area field.
  logic [5:0] pin_reg; // Shadow of the pin fields.
  logic [4:0] line; // Selected chip-enable line.
  logic rd_hit; // ROM read in the selected area.
  logic wr_hit; // ROM write in the selected area.

  // Shadow copies, so the checks need no view inside the block.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      area_reg <= 2'h0;
      if (!hot_start_i) begin
        pin_reg <= 6'h00;
      end
    end else if (reg_req_i.wr) begin
      if (reg_req_i.addr == AA) begin
        area_reg <= reg_req_i.wdata[1:0];
      end
      if (reg_req_i.addr == PA) begin
        pin_reg <= reg_req_i.wdata[5:0];
      end
    end
  end

  // Maps 00 and 01 are modelled; the paired lines of map 1x are not,
  // so the bench keeps to the first two maps.
  always_comb begin
    case ({chip_enable_map_mode_i != 2'h0, area_reg})
      3'h7: line = seq_rom_pkg::CE_M1_A3;
      3'h6: line = seq_rom_pkg::CE_M1_A2;
      3'h5: line = seq_rom_pkg::CE_M1_A1;
      3'h4: line = seq_rom_pkg::CE_M1_A0;
      3'h3: line = seq_rom_pkg::CE_M0_A3;
      3'h2: line = seq_rom_pkg::CE_M0_A2;
      3'h1: line = seq_rom_pkg::CE_M0_A1;
      default: line = seq_rom_pkg::CE_M0_A0;
    endcase
    rd_hit = !ce_n_i[line] && bus_cycle_i.rd;
    wr_hit = !ce_n_i[line] && bus_cycle_i.wr;
    rd_hit = rd_hit && (pin_reg == 6'h15);
    wr_hit = wr_hit && (pin_reg == 6'h15);
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_upper_load_le: assert property (wr_hit && bus_cycle_i.addr == 2'h3 |-> ##[2:3] pin_out_o[2:1] == 2'h3) else $error("upper load levels");
  a_lower_load_le: assert property (wr_hit && bus_cycle_i.addr == 2'h1 |-> ##[2:3] pin_out_o[2:1] == 2'h1) else $error("lower load levels");
  a_standby_le: assert property (wr_hit && bus_cycle_i.addr == 2'h2 |-> ##[2:3] pin_out_o[2:1] == 2'h2) else $error("standby levels");
  a_active_le: assert property (wr_hit && bus_cycle_i.addr == 2'h0 |-> ##[2:3] pin_out_o[2:1] == 2'h0) else $error("active levels");
  a_read_le_low: assert property (rd_hit |-> ##[2:3] pin_out_o[2:1] == 2'h0) else $error("enables not low on read");
  a_read_strobe_low: assert property (rd_hit |-> ##[1:3] !pin_out_o[0]) else $error("strobe not low on read");
  a_strobe_idle_high: assert property ((pin_reg == 6'h15 && !rd_hit)[*4] |-> pin_out_o[0]) else $error("strobe low when idle");
  a_rom_pins_driven: assert property ((pin_reg == 6'h15)[*3] |-> pin_oe_o == 3'h7) else $error("ROM pins not driven");
  a_port_pins_follow: assert property ((pin_reg == 6'h00)[*3] |-> pin_oe_o == $past(gpio_oe_i)) else $error("port enable wrong");
  a_pin_reg_read: assert property (reg_req_i.rd && reg_req_i.addr == PA |=> reg_rdata_o == {10'h000, pin_reg}) else $error("pin register read");
  a_area_reg_read: assert property (reg_req_i.rd && reg_req_i.addr == AA |=> reg_rdata_o == {14'h0000, area_reg}) else $error("area register read");
  c_upper_load: cover property (wr_hit && bus_cycle_i.addr == 2'h3);
  c_rom_read: cover property (rd_hit);
  c_fifo_pop: cover property (rd_valid_o && rd_ready_i);
endmodule // seq_rom_sva

bind sequential_rom_interface seq_rom_sva #(.DATA_WIDTH(DATA_WIDTH), .FIFO_DEPTH(FIFO_DEPTH)) u_sva (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .hot_start_i(hot_start_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .bus_cycle_i(bus_cycle_i), .ce_n_i(ce_n_i),
  .chip_enable_map_mode_i(chip_enable_map_mode_i), .rd_valid_o(rd_valid_o),
  .rd_ready_i(rd_ready_i), .gpio_oe_i(gpio_oe_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

// file: bench/seq_rom_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Behavioural sequential ROM on the far side of the pins
// ------------------------------------------------------------
module seq_rom_model #(
  parameter logic [15:0] BASE = 16'hA500 // Arbitrary content base.
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] pins_i, // Bit0 strobe, bit1 lower, bit2 upper.
  output logic [15:0] data_o
);
  logic [15:0] ptr_reg; // Read pointer.
  logic [15:0] last_reg; // Last word driven.
  logic strobe_reg; // Strobe one cycle ago.

  // The pointer restarts on an upper load and steps when a read ends.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_reg <= 16'h0000;
      last_reg <= 16'h0000;
      strobe_reg <= 1'b1;
    end else begin
      strobe_reg <= pins_i[0];
      if (pins_i[2:1] == 2'h3) begin
        ptr_reg <= 16'h0000;
      end else if (pins_i[0] && !strobe_reg) begin
        ptr_reg <= ptr_reg + 16'h0001;
      end
      if (!pins_i[0]) begin
        last_reg <= BASE + ptr_reg;
      end
    end
  end

  // Released bus shows the inverse of the last word, so a stale sample shows up.
  assign data_o = (!pins_i[0] && pins_i[2:1] == 2'h0) ? BASE + ptr_reg : ~last_reg;
endmodule // seq_rom_model

// file: bench/sequential_rom_interface_bench.sv
`timescale 1ns/1ps
module sequential_rom_interface_bench;
  localparam logic [23:0] PA = seq_rom_pkg::PIN_FUNC_ADDR;
  localparam logic [23:0] AA = seq_rom_pkg::AREA_SEL_ADDR;
  localparam logic [15:0] BASE = 16'hA500;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hot_start_i = 1'b0;
  seq_rom_pkg::reg_req_t reg_req_i = '0;
  seq_rom_pkg::bus_cycle_t bus_cycle_i = '0;
  logic [18:0] ce_n_i = '1;
  logic [1:0] chip_enable_map_mode_i = 2'h0;
  logic rd_ready_i = 1'b0;
  logic [15:0] reg_rdata_o, rom_data_i, rd_data_o;
  logic rd_valid_o, bus_wait_o;
  logic [2:0] gpio_in_o, pin_out_o, pin_oe_o, pin_in_i;
  int miscompares = 0;
  int checks = 0;

  // Undriven pins fall to a fixed pull pattern.
  assign pin_in_i = (pin_oe_o & pin_out_o) | (~pin_oe_o & 3'h5);

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  sequential_rom_interface DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .hot_start_i(hot_start_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .bus_cycle_i(bus_cycle_i), .ce_n_i(ce_n_i),
    .chip_enable_map_mode_i(chip_enable_map_mode_i),
    .bus_wait_o(bus_wait_o), .rom_data_i(rom_data_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .gpio_out_i(3'h2),
    .gpio_oe_i(3'h6), .gpio_in_o(gpio_in_o), .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

  seq_rom_model #(.BASE(BASE)) rom (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .pins_i(pin_out_o), .data_o(rom_data_i));

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [23:0] a, input logic [15:0] d);
    @(negedge clk_i) reg_req_i = {1'b0, 1'b1, a, d};
    @(negedge clk_i) reg_req_i = '0;
  endtask

  // Read data stands for the one cycle after the taking edge.
  task automatic reg_rd(input logic [23:0] a, output logic [15:0] d);
    @(negedge clk_i) reg_req_i = {1'b1, 1'b0, a, 16'h0000};
    @(negedge clk_i) reg_req_i = '0;
    d = reg_rdata_o;
  endtask

  // Reads are held several cycles so the last data sample is valid.
  task automatic rom_cyc(input logic wr, input logic [1:0] a, input int ln, input int len);
    @(negedge clk_i);
    bus_cycle_i = {~wr, wr, a};
    ce_n_i = ~(19'h00001 << ln);
    repeat (len) @(negedge clk_i);
    bus_cycle_i = '0;
    ce_n_i = '1;
    repeat (4) @(negedge clk_i);
  endtask

  // An edge passes first, so a second pop never raises ready in the
  // same step in which the first one dropped it.
  task automatic pop(input logic [15:0] exp);
    int n;
    @(negedge clk_i);
    for (n = 0; n < 20 && rd_valid_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 20) begin
      miscompares++;
      wrap_up();
    end
    check(rd_data_o, exp);
    rd_ready_i = 1'b1;
    @(negedge clk_i) rd_ready_i = 1'b0;
  endtask

  task automatic t_reset;
    logic [15:0] d;
    reg_rd(PA, d); check(d, 16'h0000);
    reg_rd(AA, d); check(d, 16'h0000);
    reg_rd(24'h300F68, d); check(d, 16'h0000);
    check({13'h0, pin_oe_o}, 16'h0006);
    check({13'h0, gpio_in_o}, 16'h0003);
    $display("test reset done");
  endtask

  task automatic t_regs;
    logic [15:0] d;
    reg_wr(PA, 16'hFFFF); reg_rd(PA, d); check(d, 16'h003F);
    reg_wr(AA, 16'hFFFF); reg_rd(AA, d); check(d, 16'h0003);
    reg_wr(AA, 16'h0000); reg_wr(PA, 16'h0015);
    repeat (3) @(negedge clk_i);
    check({13'h0, pin_oe_o}, 16'h0007);
    $display("test registers done");
  endtask

  // Fill the buffer with the consumer stalled, then drain it.
  task automatic t_load_read;
    rom_cyc(1'b1, 2'h3, 5, 1); check({14'h0, pin_out_o[2:1]}, 16'h0003);
    rom_cyc(1'b1, 2'h1, 5, 1); check({14'h0, pin_out_o[2:1]}, 16'h0001);
    for (int i = 0; i < 4; i++) rom_cyc(1'b0, 2'(i), 5, 4);
    check({14'h0, pin_out_o[2:1]}, 16'h0000);
    check({15'h0, bus_wait_o}, 16'h0001);
    for (int i = 0; i < 4; i++) pop(BASE + 16'(i));
    repeat (2) @(negedge clk_i);
    check({15'h0, rd_valid_o}, 16'h0000);
    $display("test load and read done");
  endtask

  task automatic t_area;
    reg_wr(AA, 16'h0003);
    rom_cyc(1'b0, 2'h0, 5, 4);
    check({15'h0, rd_valid_o}, 16'h0000);
    rom_cyc(1'b0, 2'h0, 9, 4);
    pop(BASE + 16'h0004);
    chip_enable_map_mode_i = 2'h1;
    rom_cyc(1'b0, 2'h0, 17, 4);
    pop(BASE + 16'h0005);
    chip_enable_map_mode_i = 2'h0;
    $display("test area done");
  endtask

  task automatic t_standby;
    rom_cyc(1'b1, 2'h2, 9, 1); check({14'h0, pin_out_o[2:1]}, 16'h0002);
    rom_cyc(1'b1, 2'h0, 9, 1); check({14'h0, pin_out_o[2:1]}, 16'h0000);
    $display("test standby done");
  endtask

  task automatic t_hot;
    logic [15:0] d;
    hot_start_i = 1'b1;
    reset_n_i = 1'b0;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    reg_rd(PA, d); check(d, 16'h0015);
    hot_start_i = 1'b0;
    reset_n_i = 1'b0;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    reg_rd(PA, d); check(d, 16'h0000);
    reg_rd(AA, d); check(d, 16'h0000);
    $display("test hot start done");
  endtask

  initial begin
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    t_reset();
    t_regs();
    t_load_read();
    t_area();
    t_standby();
    t_hot();
    wrap_up();
  end
endmodule // sequential_rom_interface_bench
